// [qrbs_ports.sv]
// Read and write ports of the quad rate burst SRAM, with storage array
`timescale 1ns/100ps
`default_nettype none
`include "qrbs_cfg.svh"

// Summary of operation
// - Read select low captures read address
// - Each read returns four words
// - Words 0,1 next cycle; 2,3 after
// - Back-to-back reads stream without gaps
// - Output clocks held high: time by input
// - Finish burst, then deselect and float outputs
// - Write select low captures write address
// - Each write stores four consecutive words
// - Write beats arrive next two cycles
// - Data outside accepted write bursts ignored
// - Lanes 0,1 gate bits 0-17
// - Lanes 2,3 gate bits 18-35
// - Low lane select writes, high keeps
// - Stopped clock holds all state
// - Impedance updates only while outputs off
// - Ports select and run independently
// - Both sequencers run on main clock
// - Two-bit linear burst address counter
// - New command in first burst cycle is ignored
module qrbs_ports
#(
  parameter int ORG18 = 0,
  parameter int ADDR_W = `QRBS_ADDR_W
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Command pins
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic [ADDR_W-1:0] shared_addr_in,
  // Write data beats of the rising and the falling half
  input wire qrbs_pkg::qrbs_beat_type wr_beat_rise,
  input wire qrbs_pkg::qrbs_beat_type wr_beat_fall,
  // Output clock pins, sampled as a mode strap
  input wire logic oclk_true_in,
  input wire logic oclk_comp_in,
  // Measured impedance code from the calibration pad
  input wire logic [`QRBS_IMP_CODE_W-1:0] impedance_set_pin,
  // Read data and driver enable
  output qrbs_pkg::qrbs_rd_out_type rd_out_r,
  // Driver strength, settle flag and timing source
  output logic [`QRBS_IMP_CODE_W-1:0] drive_code_r,
  output logic imp_settled_r,
  output logic rd_timed_by_k_r
);
  import qrbs_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Storage and sequencer state
  localparam int LANES = (ORG18 != 0) ? 2 : `QRBS_LANES; // Lanes in use
  localparam int DEPTH = 2 ** ADDR_W; // Words in the array

  logic [`QRBS_DATA_W-1:0] mem [DEPTH]; // Array, not reset
  qrbs_rd_state_type rd_state_r; // Read sequencer
  qrbs_wr_state_type wr_state_r; // Write sequencer
  logic [ADDR_W-1:0] rd_addr_r; // Captured read address
  logic [ADDR_W-1:0] wr_addr_r; // Captured write address
  logic rd_accept; // Read command taken this edge
  logic wr_accept; // Write command taken this edge
  logic [ADDR_W-1:0] rd_a0; // Read word address, even beat
  logic [ADDR_W-1:0] rd_a1; // Read word address, odd beat
  logic [ADDR_W-1:0] wr_a0; // Write word address, even beat
  logic [ADDR_W-1:0] wr_a1; // Write word address, odd beat
  logic [`QRBS_DATA_W-1:0] wr_w0; // Merged even word
  logic [`QRBS_DATA_W-1:0] wr_w1; // Merged odd word
  logic wr_active; // Write beats due this edge

  //////////////////////////////////////////////////////////////////////
  // Command acceptance
  // A command landing in the first cycle of a running burst would cut it
  // short, so it is dropped; the last cycle may take the next command.
  // mid-burst drop
  assign rd_accept = !rd_sel_n && (rd_state_r != RD_B01);
  assign wr_accept = !wr_sel_n && (wr_state_r != WR_B01);

  //////////////////////////////////////////////////////////////////////
  // Read sequencer
  // independent read port
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rd_state_r <= RD_IDLE;
    // New burst, also straight after the last pair of an old one
    else if (rd_accept)
      rd_state_r <= RD_B01;
    else if (rd_state_r == RD_B01)
      rd_state_r <= RD_B23;
    // Burst done or no command: back to deselect
    else
      rd_state_r <= RD_IDLE;
  end

  // Read address capture
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rd_addr_r <= '0;
    else if (rd_accept)
      rd_addr_r <= shared_addr_in;
  end

  //////////////////////////////////////////////////////////////////////
  // Write sequencer
  // independent write port
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      wr_state_r <= WR_IDLE;
    else if (wr_accept)
      wr_state_r <= WR_B01;
    else if (wr_state_r == WR_B01)
      wr_state_r <= WR_B23;
    else
      wr_state_r <= WR_IDLE;
  end

  // Write address capture
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      wr_addr_r <= '0;
    else if (wr_accept)
      wr_addr_r <= shared_addr_in;
  end

  //////////////////////////////////////////////////////////////////////
  // Burst addresses
  // Only the low two bits count, so a burst wraps within its aligned
  // group of four; a start at offset 3 goes 3,0,1,2.
  // linear burst count
  always_comb
  begin
    rd_a0 = rd_addr_r;
    rd_a1 = rd_addr_r;
    wr_a0 = wr_addr_r;
    wr_a1 = wr_addr_r;
    rd_a0[1:0] = rd_addr_r[1:0] + ((rd_state_r == RD_B23) ? 2'h2 : 2'h0);
    rd_a1[1:0] = rd_a0[1:0] + 2'h1;
    wr_a0[1:0] = wr_addr_r[1:0] + ((wr_state_r == WR_B23) ? 2'h2 : 2'h0);
    wr_a1[1:0] = wr_a0[1:0] + 2'h1;
  end

  //////////////////////////////////////////////////////////////////////
  // Write lane merge
  // Each lane takes the new byte when its select is low and keeps the
  // stored byte otherwise; unused lanes of the 18-bit build never write.
  assign wr_active = (wr_state_r == WR_B01) || (wr_state_r == WR_B23);

  for (genvar g = 0; g < `QRBS_LANES; g++)
  begin : g_lane
    logic en0; // Lane enable, even beat
    logic en1; // Lane enable, odd beat
    assign en0 = (g < LANES) && !wr_beat_rise.mask[g];
    assign en1 = (g < LANES) && !wr_beat_fall.mask[g];
    assign wr_w0[g*`QRBS_LANE_W +: `QRBS_LANE_W] = en0 ?
      wr_beat_rise.data[g*`QRBS_LANE_W +: `QRBS_LANE_W] :
      mem[wr_a0][g*`QRBS_LANE_W +: `QRBS_LANE_W];
    assign wr_w1[g*`QRBS_LANE_W +: `QRBS_LANE_W] = en1 ?
      wr_beat_fall.data[g*`QRBS_LANE_W +: `QRBS_LANE_W] :
      mem[wr_a1][g*`QRBS_LANE_W +: `QRBS_LANE_W];
  end

  //////////////////////////////////////////////////////////////////////
  // Array write
  // Two beats land per cycle, rising half at the even burst address.
  always_ff @(posedge clock)
  begin
    if (wr_active)
    begin
      mem[wr_a0] <= wr_w0;
      mem[wr_a1] <= wr_w1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read output register
  // Loaded one edge after each sequencer state, so words 0,1 show in the
  // cycle after the command and words 2,3 in the one after that. With no
  // clock edges every register here simply holds, which freezes the pins.
  // hold when stopped
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_out_r.data_rise <= `QRBS_DATA_RST;
      rd_out_r.data_fall <= `QRBS_DATA_RST;
      rd_out_r.oe <= 1'b0;
    end
    else if (rd_state_r != RD_IDLE)
    begin
      rd_out_r.data_rise <= mem[rd_a0];
      rd_out_r.data_fall <= mem[rd_a1];
      rd_out_r.oe <= 1'b1;
    end
    else
    begin
      rd_out_r.oe <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Single-clock mode strap
  // Caught once after reset; switching it later is not supported.
  logic strap_done_r; // Strap already caught

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      strap_done_r <= 1'b0;
      rd_timed_by_k_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      rd_timed_by_k_r <= oclk_true_in && oclk_comp_in;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Impedance code synchroniser
  // The pad code is analogue-derived and free-running: three stages, and
  // a change counts only when the last two agree.
  logic [`QRBS_IMP_CODE_W-1:0] imp_s1_r; // First stage
  logic [`QRBS_IMP_CODE_W-1:0] imp_s2_r; // Second stage
  logic [`QRBS_IMP_CODE_W-1:0] imp_s3_r; // Third stage
  logic [`QRBS_IMP_CODE_W-1:0] imp_code_r; // Agreed code

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      imp_s1_r <= `QRBS_IMP_CODE_RST;
      imp_s2_r <= `QRBS_IMP_CODE_RST;
      imp_s3_r <= `QRBS_IMP_CODE_RST;
      imp_code_r <= `QRBS_IMP_CODE_RST;
    end
    else
    begin
      imp_s1_r <= impedance_set_pin;
      imp_s2_r <= imp_s1_r;
      imp_s3_r <= imp_s2_r;
      if (imp_s2_r == imp_s3_r)
      begin
        imp_code_r <= imp_s3_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Driver strength update
  // Applied only in a cycle with drivers off and no read pending, so a
  // strength step never lands inside a burst and cannot push out data.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      drive_code_r <= `QRBS_IMP_CODE_RST;
    else if (!rd_out_r.oe && (rd_state_r == RD_IDLE))
      drive_code_r <= imp_code_r;
  end

  //////////////////////////////////////////////////////////////////////
  // Impedance settle counter
  // Counts non-read cycles after reset and saturates; the flag only
  // informs the controller, reads are served before it anyway.
  logic [`QRBS_IMP_CNT_W-1:0] settle_cnt_r; // Non-read cycles seen

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      settle_cnt_r <= '0;
      imp_settled_r <= 1'b0;
    end
    else if (!imp_settled_r && !rd_accept)
    begin
      settle_cnt_r <= settle_cnt_r + `QRBS_IMP_CNT_W'(1);
      imp_settled_r <= (settle_cnt_r == `QRBS_IMP_CNT_W'(`QRBS_IMP_SETTLE_CYC - 1));
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Assertions
  // Output enabled for a whole burst; the register loads one edge after
  // the command edge, so the enable is first seen two edges on
  sequence s_burst_out;
    ##2 rd_out_r.oe ##1 rd_out_r.oe;
  endsequence

  property p_rd_capture;
    @(posedge clock) disable iff (!rstn)
    rd_accept |=> (rd_addr_r == $past(shared_addr_in)) && (rd_state_r == RD_B01);
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("read address not captured");
  property p_rd_burst;
    @(posedge clock) disable iff (!rstn)
    rd_accept |-> s_burst_out;
  endproperty
  a_rd_burst: assert property (p_rd_burst) else $error("read burst not driven");
  property p_rd_gapless;
    @(posedge clock) disable iff (!rstn)
    (rd_accept && (rd_state_r == RD_B23)) |-> ##1 rd_out_r.oe [*3];
  endproperty
  a_rd_gapless: assert property (p_rd_gapless) else $error("gap between bursts");
  property p_rd_deselect;
    @(posedge clock) disable iff (!rstn)
    (rd_state_r == RD_IDLE) |=> !rd_out_r.oe;
  endproperty
  a_rd_deselect: assert property (p_rd_deselect) else $error("drivers on while idle");
  property p_wr_capture;
    @(posedge clock) disable iff (!rstn)
    wr_accept |=> (wr_addr_r == $past(shared_addr_in)) ##1 (wr_state_r == WR_B23);
  endproperty
  a_wr_capture: assert property (p_wr_capture) else $error("write address not captured");
  // The address was loaded at the edge before, so it must hold over the next one
  property p_no_interrupt;
    @(posedge clock) disable iff (!rstn)
    (wr_state_r == WR_B01) |-> !wr_accept ##1 $stable(wr_addr_r);
  endproperty
  a_no_interrupt: assert property (p_no_interrupt) else $error("write burst interrupted");
  property p_imp_quiet;
    @(posedge clock) disable iff (!rstn)
    rd_out_r.oe |=> $stable(drive_code_r);
  endproperty
  a_imp_quiet: assert property (p_imp_quiet) else $error("impedance changed during read");
  property p_port_indep;
    @(posedge clock) disable iff (!rstn)
    ((rd_state_r == RD_IDLE) && rd_sel_n) |=> (rd_state_r == RD_IDLE);
  endproperty
  a_port_indep: assert property (p_port_indep) else $error("read started without select");
  property p_mode_fixed;
    @(posedge clock) disable iff (!rstn)
    strap_done_r |=> $stable(rd_timed_by_k_r);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("clock mode changed");

endmodule
`default_nettype wire

// [qrbs_cfg.svh]
// Constants of the quad rate burst SRAM ports: widths, reset values, counts
`ifndef QRBS_CFG_SVH
`define QRBS_CFG_SVH

// Organisation: full data width, lane width and lane count
`define QRBS_DATA_W 36
`define QRBS_LANE_W 9
`define QRBS_LANES 4
// Address width of the 36-bit organisation; the 18-bit one has one more bit
`define QRBS_ADDR_W 19
// Burst length and the width of the linear burst counter
`define QRBS_BURST_LEN 4
`define QRBS_BURST_CNT_W 2
// Non-read cycles before the output impedance is trusted
`define QRBS_IMP_SETTLE_CYC 1024
`define QRBS_IMP_CNT_W 11
// Impedance code width and its reset value
`define QRBS_IMP_CODE_W 6
`define QRBS_IMP_CODE_RST 6'h20
// Read data reset value
`define QRBS_DATA_RST 36'h000000000

`endif

// [qrbs_pkg.sv]
// Types shared by the quad rate burst SRAM ports
`include "qrbs_cfg.svh"

package qrbs_pkg;

  // Active-low byte lane write selects sampled with one data beat
  typedef struct packed {
    logic byte_lane3_mask_n;
    logic byte_lane2_mask_n;
    logic byte_lane1_mask_n;
    logic byte_lane0_mask_n;
  } qrbs_mask_type;

  // One write data beat together with its lane selects
  typedef struct packed {
    qrbs_mask_type mask;
    logic [`QRBS_DATA_W-1:0] data;
  } qrbs_beat_type;

  // One cycle of read port output: two words and the driver enable
  typedef struct packed {
    logic [`QRBS_DATA_W-1:0] data_rise;
    logic [`QRBS_DATA_W-1:0] data_fall;
    logic oe;
  } qrbs_rd_out_type;

  // Read port sequencer
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_B01 = 2'h1,
    RD_B23 = 2'h2
  } qrbs_rd_state_type;

  // Write port sequencer
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_B01 = 2'h1,
    WR_B23 = 2'h2
  } qrbs_wr_state_type;

endpackage

// [qrbs_ctrl_model.sv]
// Memory controller model that drives the pins of the quad rate burst SRAM ports
`timescale 1ns/100ps
`default_nettype none
`include "qrbs_cfg.svh"

module qrbs_ctrl_model
(
  // Clock
  input wire logic clock,
  // Mode strap level and calibration code chosen by the bench
  input wire logic single_clk,
  input wire logic [`QRBS_IMP_CODE_W-1:0] imp_code,
  // Command pins toward the device
  output logic rd_sel_n,
  output logic wr_sel_n,
  output logic [`QRBS_ADDR_W-1:0] shared_addr_in,
  // Write data beats toward the device
  output qrbs_pkg::qrbs_beat_type wr_beat_rise,
  output qrbs_pkg::qrbs_beat_type wr_beat_fall,
  // Output clock pins and calibration pad
  output logic oclk_true_in,
  output logic oclk_comp_in,
  output logic [`QRBS_IMP_CODE_W-1:0] impedance_set_pin
);
  import qrbs_pkg::*;

  // Beat pairs still owed for an accepted write burst
  qrbs_beat_type p1r, p1f, p2r, p2f;
  logic p1v, p2v;

  assign oclk_true_in = single_clk;
  assign oclk_comp_in = single_clk;
  assign impedance_set_pin = imp_code;

  ////////////////////////////////////////////////////////////////////////////
  // selects idle high
  initial
  begin
    rd_sel_n = 1'b1;
    wr_sel_n = 1'b1;
    shared_addr_in = '0;
    wr_beat_rise = '0;
    wr_beat_fall = '0;
    p1v = 1'b0;
    p2v = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One controller cycle; a write is only started when no burst is owed
  task automatic step(input logic rd, input logic wr, input logic [`QRBS_ADDR_W-1:0] a,
    input logic [143:0] w, input logic [15:0] m);
    @(posedge clock);
    rd_sel_n <= ~rd;
    wr_sel_n <= ~wr;
    shared_addr_in <= (rd | wr) ? a : ~shared_addr_in;
    if (p1v)
    begin
      wr_beat_rise <= p1r;
      wr_beat_fall <= p1f;
    end
    else
    begin
      // Released lines flip so stale data can never look valid
      wr_beat_rise <= ~wr_beat_rise;
      wr_beat_fall <= ~wr_beat_fall;
    end
    p1r = p2r;
    p1f = p2f;
    p1v = p2v;
    p2v = 1'b0;
    if (wr && !p1v)
    begin
      p1r = qrbs_beat_type'({m[3:0], w[35:0]});
      p1f = qrbs_beat_type'({m[7:4], w[71:36]});
      p2r = qrbs_beat_type'({m[11:8], w[107:72]});
      p2f = qrbs_beat_type'({m[15:12], w[143:108]});
      p1v = 1'b1;
      p2v = 1'b1;
    end
  endtask

endmodule
`default_nettype wire

// [qrbs_ports_test.sv]
// Self-checking testbench of the quad rate burst SRAM ports
`timescale 1ns/100ps
`default_nettype none
`include "qrbs_cfg.svh"

module qrbs_ports_test;
  import qrbs_pkg::*;

  // One controller cycle of stimulus
  typedef struct packed {
    logic rd;
    logic wr;
    logic [18:0] a;
    logic [143:0] w;
    logic [15:0] m;
  } qrbs_row_type;

  // Clock, reset and bench controls
  logic clock, rstn, single_clk;
  logic [5:0] imp_code;
  // Pins between model and device
  logic rd_sel_n, wr_sel_n, oclk_true_in, oclk_comp_in;
  logic [18:0] shared_addr_in;
  logic [5:0] impedance_set_pin, drive_code_r;
  qrbs_beat_type wr_beat_rise, wr_beat_fall;
  qrbs_rd_out_type rd_out_r;
  logic imp_settled_r, rd_timed_by_k_r;
  // Reference memory, expected read slots and counters
  logic [35:0] mem [int];
  logic eo [4];
  logic [71:0] ed [4];
  logic rbusy, wbusy;
  int miscompares, checks_done, cyc, i;
  qrbs_row_type rows [$];

  qrbs_ctrl_model m (.clock(clock), .single_clk(single_clk), .imp_code(imp_code),
    .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .shared_addr_in(shared_addr_in),
    .wr_beat_rise(wr_beat_rise), .wr_beat_fall(wr_beat_fall), .oclk_true_in(oclk_true_in),
    .oclk_comp_in(oclk_comp_in), .impedance_set_pin(impedance_set_pin));

  qrbs_ports dut (.clock(clock), .rstn(rstn), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n),
    .shared_addr_in(shared_addr_in), .wr_beat_rise(wr_beat_rise),
    .wr_beat_fall(wr_beat_fall), .oclk_true_in(oclk_true_in), .oclk_comp_in(oclk_comp_in),
    .impedance_set_pin(impedance_set_pin), .rd_out_r(rd_out_r), .drive_code_r(drive_code_r),
    .imp_settled_r(imp_settled_r), .rd_timed_by_k_r(rd_timed_by_k_r));

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one per kind of result
  task automatic chk1(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk6(input string n, input logic [5:0] e, input logic [5:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk72(input string n, input logic [71:0] e, input logic [71:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Row builder: word k is the base plus k times a stride
  function automatic qrbs_row_type mk(input logic rd, input logic wr, input logic [18:0] a,
    input logic [35:0] b, input logic [15:0] mk_m);
    qrbs_row_type r;
    r = '{rd, wr, a, '0, mk_m};
    for (int k = 0; k < 4; k++)
      r.w[36*k +: 36] = b + 36'(k) * 36'h111111111;
    return r;
  endfunction

  // Drive one cycle and work out what the device must answer
  task automatic go(input qrbs_row_type r);
    logic [18:0] ba;
    m.step(r.rd, r.wr, r.a, r.w, r.m);
    cyc++;
    for (int k = 0; k < 4; k++)
    begin
      // Burst address wraps inside its group of four
      ba = {r.a[18:2], r.a[1:0] + 2'(k)};
      if (r.rd && !rbusy)
      begin
        eo[(cyc + 2 + k / 2) % 4] = 1'b1;
        ed[(cyc + 2 + k / 2) % 4][71 - 36 * (k % 2) -: 36] = mem[ba];
      end
      for (int l = 0; l < 4; l++)
        if (r.wr && !wbusy && !r.m[4 * k + l])
          mem[ba][9 * l +: 9] = r.w[36 * k + 9 * l +: 9];
    end
    rbusy = r.rd && !rbusy;
    wbusy = r.wr && !wbusy;
  endtask

  // Read port watched in the middle of every cycle out of reset
  always @(negedge clock)
    if (rstn)
    begin
      chk1("oe", eo[cyc % 4], rd_out_r.oe);
      if (eo[cyc % 4])
        chk72("read data", ed[cyc % 4], {rd_out_r.data_rise, rd_out_r.data_fall});
      eo[cyc % 4] = 1'b0;
    end

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    #40000;
    miscompares++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    single_clk = 1'b1;
    imp_code = 6'h2a;
    rbusy = 1'b0;
    wbusy = 1'b0;
    cyc = 0;
    miscompares = 0;
    checks_done = 0;
    for (i = 0; i < 4; i++)
      eo[i] = 1'b0;
    repeat (2) @(posedge clock);
    chk6("drive code reset", 6'h20, drive_code_r);
    chk1("settled reset", 1'b0, imp_settled_r);
    rstn <= 1'b1;
    for (i = 0; i < 1000; i++)
      go(mk(0, 0, 0, 0, 0));
    // Look mid-cycle, once the edge's updates have settled
    @(negedge clock);
    chk1("single clock mode", 1'b1, rd_timed_by_k_r);
    chk1("settled early", 1'b0, imp_settled_r);
    chk6("drive code idle", 6'h2a, drive_code_r);
    for (i = 0; i < 40; i++)
      go(mk(0, 0, 0, 0, 0));
    @(negedge clock);
    chk1("settled", 1'b1, imp_settled_r);
    // Writes, lane masking, wrapping bursts and reads, some overlapped
    rows.push_back(mk(0, 1, 19'h00010, 36'h0a1b2c3d4, 16'h0000));
    rows.push_back(mk(0, 0, 0, 0, 0));
    rows.push_back(mk(0, 1, 19'h00021, 36'h1f0e0d0c0, 16'h0000));
    rows.push_back(mk(0, 0, 0, 0, 0));
    rows.push_back(mk(0, 1, 19'h00054, 36'h355aa55aa, 16'h0000));
    rows.push_back(mk(0, 0, 0, 0, 0));
    rows.push_back(mk(0, 1, 19'h00010, 36'h9c8c7c6c5, 16'hf3de));
    rows.push_back(mk(1, 0, 19'h00021, 0, 0));
    rows.push_back(mk(0, 0, 0, 0, 0));
    rows.push_back(mk(1, 0, 19'h00010, 0, 0));
    rows.push_back(mk(0, 0, 0, 0, 0));
    rows.push_back(mk(1, 0, 19'h00054, 0, 0));
    foreach (rows[j])
      go(rows[j]);
    repeat (4) go(mk(0, 0, 0, 0, 0));
    // Commands one cycle into a burst are dropped
    go(mk(0, 1, 19'h00050, 36'h444444444, 16'h0000));
    go(mk(0, 1, 19'h00054, 36'h777777777, 16'h0000));
    go(mk(0, 0, 0, 0, 0));
    go(mk(1, 0, 19'h00054, 0, 0));
    go(mk(1, 0, 19'h00050, 0, 0));
    go(mk(1, 0, 19'h00050, 0, 0));
    repeat (4) go(mk(0, 0, 0, 0, 0));
    // New impedance code held off while reads stream
    imp_code <= 6'h15;
    for (i = 0; i < 12; i++)
    begin
      go(mk(i % 2 == 0, 0, 19'h00010, 0, 0));
      @(negedge clock);
      chk6("drive code busy", 6'h2a, drive_code_r);
    end
    repeat (10) go(mk(0, 0, 0, 0, 0));
    @(negedge clock);
    chk6("drive code applied", 6'h15, drive_code_r);
    // Second reset with output clock pins held low
    @(posedge clock);
    rstn <= 1'b0;
    single_clk <= 1'b0;
    repeat (2) @(posedge clock);
    chk1("oe in reset", 1'b0, rd_out_r.oe);
    rstn <= 1'b1;
    repeat (3) go(mk(0, 0, 0, 0, 0));
    @(negedge clock);
    chk1("two clock mode", 1'b0, rd_timed_by_k_r);
    go(mk(1, 0, 19'h00021, 0, 0));
    repeat (5) go(mk(0, 0, 0, 0, 0));
    complete_run();
  end

endmodule
`default_nettype wire
